/* File: cxs_pkg.sv */
/*
 Shared constants and types for the control transfer and state access
 execution block. Assumes one 100 MHz clock and an external register file.
*/
package cxs_pkg;
  // ==========================================================
  // Window and state register layout
  localparam logic [4:0]  WINDOW_COUNT = 5'h08;  // Implemented windows
  localparam logic [4:0]  WINDOW_LAST  = 5'h07;  // Highest window index
  localparam int          CWP_LSB      = 0;      // Window pointer field
  localparam int          CWP_MSB      = 4;
  localparam int          ET_BIT       = 5;      // Trap enable
  localparam int          PS_BIT       = 6;      // Previous supervisor
  localparam int          S_BIT        = 7;      // Supervisor
  localparam int          TT_MSB       = 6;      // Software trap type top
  localparam logic [31:0] PSR_RESET    = 32'h0000_0080;
  localparam logic [31:0] PC_RESET     = 32'h0000_0000;
  localparam logic [31:0] NPC_RESET    = 32'h0000_0004;
  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
  localparam logic [31:0] PC_STEP      = 32'h0000_0004;
  // ==========================================================
  // Register indices and condition field values
  localparam logic [4:0]  LINK_REG     = 5'h0F;  // Call link register
  localparam logic [4:0]  ZERO_REG     = 5'h00;
  localparam logic [3:0]  COND_ALWAYS  = 4'hF;   // Branch mask, all terms
  localparam logic [3:0]  COND_NEVER   = 4'h0;
  localparam logic [3:0]  TCOND_NEVER  = 4'h0;   // Trap never
  localparam logic [3:0]  TCOND_ALWAYS = 4'h8;   // Trap always
  // ==========================================================
  // Decoded operations
  typedef enum logic [4:0] {
    OP_NONE, OP_FP_BRANCH, OP_CP_BRANCH, OP_CALL, OP_JUMP_LINK,
    OP_RETURN_TRAP, OP_COND_TRAP, OP_READ_MULT, OP_READ_STATE,
    OP_READ_MASK, OP_READ_TRAP_BASE, OP_WRITE_MULT, OP_WRITE_STATE,
    OP_WRITE_MASK, OP_WRITE_TRAP_BASE, OP_UNIMPL, OP_FLUSH
  } cxs_op_t;
  // Trap causes reported to exception logic
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_ILLEGAL, CAUSE_PRIVILEGED, CAUSE_UNDERFLOW,
    CAUSE_MISALIGNED, CAUSE_SOFTWARE
  } cxs_cause_t;
  // ==========================================================
  // Carriers
  typedef struct packed {
    cxs_op_t     op;
    logic [4:0]  rd;
    logic [3:0]  cond;
    logic        annul;
    logic        imm_sel;
    logic [12:0] signed_immediate;
    logic [21:0] branch_displacement;
    logic [29:0] call_displacement;
  } cxs_instr_t;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cxs_icc_t;
  typedef struct packed {
    logic        we;
    logic [4:0]  idx;
    logic [31:0] data;
  } cxs_rf_wr_t;
  typedef struct packed {
    logic       valid;
    cxs_cause_t cause;
    logic [6:0] ttype;
  } cxs_trap_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } cxs_flush_t;
endpackage : cxs_pkg

/* File: cxs_exec.sv */
/*
 Execution of condition-code branches, call, jump and link, return from
 trap, conditional traps, state register access, unimplemented op and
 instruction cache flush. Assumes a decoder upstream, an external
 register file and exception logic that consume the registered results.
*/
`timescale 1ns/10ps
module cxs_exec (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  // Decoded instruction and operands
  input  wire logic                op_valid_in,
  input  wire cxs_pkg::cxs_instr_t op_in,
  input  wire logic [31:0]         src1_in,
  input  wire logic [31:0]         src2_in,
  output wire logic                op_ready_out,
  // Condition codes
  input  wire cxs_pkg::cxs_icc_t   icc_in,
  input  wire logic [1:0]          fcc_in,
  input  wire logic                fcc_valid_in,
  input  wire logic [1:0]          coproc_condition_input_in,
  input  wire logic                coproc_cc_valid_in,
  // Cache configuration
  input  wire logic                local_icache_present_in,
  input  wire logic                external_icache_present_in,
  // Architectural state
  output logic [31:0]              pc_out,
  output logic [31:0]              next_program_counter_out,
  output logic [31:0]              state_out,
  output logic [31:0]              window_invalid_mask_out,
  output logic [31:0]              trap_base_out,
  output logic [31:0]              multiply_out,
  // Results
  output cxs_pkg::cxs_rf_wr_t      rf_wr_out,
  output cxs_pkg::cxs_trap_t       trap_out,
  output logic                     annul_out,
  output cxs_pkg::cxs_flush_t      flush_out
);
  // ==========================================================
  // State registers
  logic [31:0]         pc_r,   pc_nxt;    // Program counter
  logic [31:0]         npc_r,  npc_nxt;   // Next program counter
  logic [31:0]         psr_r,  psr_nxt;   // Processor state
  logic [31:0]         wim_r,  wim_nxt;   // Window invalid mask
  logic [31:0]         tbr_r,  tbr_nxt;   // Trap base
  logic [31:0]         y_r,    y_nxt;     // Multiply step
  cxs_pkg::cxs_rf_wr_t wr_r,   wr_nxt;    // Register file write
  cxs_pkg::cxs_trap_t  trap_r, trap_nxt;  // Trap report
  cxs_pkg::cxs_flush_t fl_r,   fl_nxt;    // Flush request
  logic                ann_r,  ann_nxt;   // Delay slot annul
  // ==========================================================
  // Decode and datapath
  wire cxs_pkg::cxs_op_t op = op_in.op;
  wire        is_fbr  = (op == cxs_pkg::OP_FP_BRANCH);
  wire        is_cbr  = (op == cxs_pkg::OP_CP_BRANCH);
  wire        is_br   = is_fbr | is_cbr;
  // Hold while the producing unit owes its code
  wire        stall   = (is_fbr & ~fcc_valid_in) |
                        (is_cbr & ~coproc_cc_valid_in);
  wire        accept  = op_valid_in & ~stall;
  wire        sup     = psr_r[cxs_pkg::S_BIT];
  wire        et      = psr_r[cxs_pkg::ET_BIT];
  wire [4:0]  cwp     = psr_r[cxs_pkg::CWP_MSB:cxs_pkg::CWP_LSB];
  wire [31:0] simm_x  = {{19{op_in.signed_immediate[12]}},
                         op_in.signed_immediate};
  wire [31:0] oper2   = op_in.imm_sel ? simm_x : src2_in;
  wire [31:0] sum     = src1_in + oper2;
  wire [31:0] xres    = src1_in ^ oper2;
  wire        misal   = |sum[1:0];
  wire [6:0]  tt_val  = sum[cxs_pkg::TT_MSB:0];
  wire [31:0] seq_npc = npc_r + cxs_pkg::PC_STEP;
  wire [31:0] br_tgt  = pc_r + {{8{op_in.branch_displacement[21]}},
                                op_in.branch_displacement,
                                2'b00};
  wire [31:0] call_tgt = pc_r + {op_in.call_displacement, 2'b00};
  // Candidate window wraps at the implemented count
  wire [4:0]  cwp_cand = (cwp == cxs_pkg::WINDOW_LAST) ? 5'h00 :
                         5'(cwp + 5'h01);
  wire        wim_hit  = wim_r[cwp_cand];
  wire        bad_cwp  = (xres[4:0] >= cxs_pkg::WINDOW_COUNT);
  wire        rd_zero  = (op_in.rd == cxs_pkg::ZERO_REG);
  // ==========================================================
  // Condition evaluation
  logic [3:0] fcc_hot;   // Bit k: float code equals k
  logic [3:0] ccc_hot;   // Bit k: coprocessor code equals k
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_hot
      assign fcc_hot[k] = (fcc_in == 2'(k));
      assign ccc_hot[k] =
        (coproc_condition_input_in == 2'(k));
    end
  endgenerate
  // Condition mask picks relations; all set is always, none is never
  wire        fp_eval = |(op_in.cond & fcc_hot);
  wire        cp_eval = |(op_in.cond & ccc_hot);
  wire        taken   = is_fbr ? fp_eval : cp_eval;
  wire        br_alw  = (op_in.cond == cxs_pkg::COND_ALWAYS);
  // Integer relations; top condition bit inverts
  wire        nxv     = icc_in.n ^ icc_in.v;
  wire [7:0]  icc_rel = {icc_in.v, icc_in.n, icc_in.c,
                         icc_in.c | icc_in.z, nxv,
                         icc_in.z | nxv, icc_in.z, 1'b0};
  wire        t_eval  = icc_rel[op_in.cond[2:0]] ^ op_in.cond[3];
  // ==========================================================
  // Next state; each trap leaves all state untouched
  always_comb begin
    pc_nxt   = pc_r;
    npc_nxt  = npc_r;
    psr_nxt  = psr_r;
    wim_nxt  = wim_r;
    tbr_nxt  = tbr_r;
    y_nxt    = y_r;
    wr_nxt   = '0;
    trap_nxt = '0;
    fl_nxt   = '0;
    ann_nxt  = 1'b0;
    if (accept) begin
      case (op)
        cxs_pkg::OP_FP_BRANCH, cxs_pkg::OP_CP_BRANCH: begin
          pc_nxt = npc_r;
          if (taken) begin
            npc_nxt = br_tgt;
            ann_nxt = op_in.annul & br_alw;
          end else begin
            npc_nxt = seq_npc;
            ann_nxt = op_in.annul;
          end
        end
        cxs_pkg::OP_CALL: begin
          wr_nxt  = '{1'b1, cxs_pkg::LINK_REG, pc_r};
          pc_nxt  = npc_r;
          npc_nxt = call_tgt;
        end
        cxs_pkg::OP_JUMP_LINK: begin
          if (misal) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_MISALIGNED, 7'h00};
          end else begin
            wr_nxt  = '{~rd_zero, op_in.rd, pc_r};
            pc_nxt  = npc_r;
            npc_nxt = sum;
          end
        end
        cxs_pkg::OP_RETURN_TRAP: begin
          // Checks in fixed priority order
          if (et) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_ILLEGAL, 7'h00};
          end else if (!sup) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_PRIVILEGED, 7'h00};
          end else if (wim_hit) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_UNDERFLOW, 7'h00};
          end else if (misal) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_MISALIGNED, 7'h00};
          end else begin
            psr_nxt[cxs_pkg::ET_BIT] = 1'b1;
            psr_nxt[cxs_pkg::S_BIT]  = psr_r[cxs_pkg::PS_BIT];
            psr_nxt[cxs_pkg::CWP_MSB:cxs_pkg::CWP_LSB] = cwp_cand;
            pc_nxt  = npc_r;
            npc_nxt = sum;
          end
        end
        cxs_pkg::OP_COND_TRAP: begin
          if (t_eval) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_SOFTWARE, tt_val};
          end else begin
            pc_nxt  = npc_r;
            npc_nxt = seq_npc;
          end
        end
        cxs_pkg::OP_READ_MULT: begin
          wr_nxt  = '{~rd_zero, op_in.rd, y_r};
          pc_nxt  = npc_r;
          npc_nxt = seq_npc;
        end
        cxs_pkg::OP_READ_STATE, cxs_pkg::OP_READ_MASK,
        cxs_pkg::OP_READ_TRAP_BASE: begin
          if (!sup) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_PRIVILEGED, 7'h00};
          end else begin
            wr_nxt.we   = ~rd_zero;
            wr_nxt.idx  = op_in.rd;
            wr_nxt.data = (op == cxs_pkg::OP_READ_STATE) ? psr_r :
                          (op == cxs_pkg::OP_READ_MASK)  ? wim_r : tbr_r;
            pc_nxt  = npc_r;
            npc_nxt = seq_npc;
          end
        end
        cxs_pkg::OP_WRITE_MULT: begin
          y_nxt   = xres;
          pc_nxt  = npc_r;
          npc_nxt = seq_npc;
        end
        cxs_pkg::OP_WRITE_STATE: begin
          if (bad_cwp) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_ILLEGAL, 7'h00};
          end else if (!sup) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_PRIVILEGED, 7'h00};
          end else begin
            psr_nxt = xres;
            pc_nxt  = npc_r;
            npc_nxt = seq_npc;
          end
        end
        cxs_pkg::OP_WRITE_MASK, cxs_pkg::OP_WRITE_TRAP_BASE: begin
          if (!sup) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_PRIVILEGED, 7'h00};
          end else begin
            if (op == cxs_pkg::OP_WRITE_MASK) begin
              wim_nxt = xres;
            end else begin
              tbr_nxt = xres;
            end
            pc_nxt  = npc_r;
            npc_nxt = seq_npc;
          end
        end
        cxs_pkg::OP_UNIMPL: begin
          trap_nxt = '{1'b1, cxs_pkg::CAUSE_ILLEGAL, 7'h00};
        end
        cxs_pkg::OP_FLUSH: begin
          if (local_icache_present_in) begin
            fl_nxt  = '{1'b1, sum};
            pc_nxt  = npc_r;
            npc_nxt = seq_npc;
          end else if (external_icache_present_in) begin
            trap_nxt = '{1'b1, cxs_pkg::CAUSE_ILLEGAL, 7'h00};
          end else begin
            pc_nxt  = npc_r;
            npc_nxt = seq_npc;
          end
        end
        default: begin
          pc_nxt = pc_r;
        end
      endcase
    end
  end
  // ==========================================================
  // State update
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_r   <= cxs_pkg::PC_RESET;
      npc_r  <= cxs_pkg::NPC_RESET;
      psr_r  <= cxs_pkg::PSR_RESET;
      wim_r  <= cxs_pkg::WORD_RESET;
      tbr_r  <= cxs_pkg::WORD_RESET;
      y_r    <= cxs_pkg::WORD_RESET;
    end else begin
      pc_r   <= pc_nxt;
      npc_r  <= npc_nxt;
      psr_r  <= psr_nxt;
      wim_r  <= wim_nxt;
      tbr_r  <= tbr_nxt;
      y_r    <= y_nxt;
    end
  end
  // One-cycle result pulses
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_r   <= '0;
      trap_r <= '0;
      fl_r   <= '0;
      ann_r  <= 1'b0;
    end else begin
      wr_r   <= wr_nxt;
      trap_r <= trap_nxt;
      fl_r   <= fl_nxt;
      ann_r  <= ann_nxt;
    end
  end
  // ==========================================================
  // Outputs
  assign op_ready_out             = ~stall;
  assign pc_out                   = pc_r;
  assign next_program_counter_out = npc_r;
  assign state_out                = psr_r;
  assign window_invalid_mask_out  = wim_r;
  assign trap_base_out            = tbr_r;
  assign multiply_out             = y_r;
  assign rf_wr_out                = wr_r;
  assign trap_out                 = trap_r;
  assign annul_out                = ann_r;
  assign flush_out                = fl_r;
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_taken_br;
    accept && is_br && taken;
  endsequence
  sequence s_untaken_br;
    accept && is_br && !taken;
  endsequence
  branch_target_a: assert property (
    s_taken_br |=> npc_r == $past(br_tgt) && pc_r == $past(npc_r))
    else $error("taken branch counters wrong");
  branch_annul_a: assert property (
    s_untaken_br |=> npc_r == $past(seq_npc) &&
      annul_out == $past(op_in.annul))
    else $error("untaken branch annul or step wrong");
  always_annul_a: assert property (
    s_taken_br ##0 (br_alw && op_in.annul) |=> annul_out)
    else $error("always branch did not annul");
  fp_always_a: assert property (
    accept && is_fbr && br_alw |-> taken)
    else $error("always branch not taken");
  call_link_a: assert property (
    accept && op == cxs_pkg::OP_CALL |=> rf_wr_out.we &&
      rf_wr_out.idx == cxs_pkg::LINK_REG &&
      rf_wr_out.data == $past(pc_r) && npc_r == $past(call_tgt))
    else $error("call link wrong");
  jump_misal_a: assert property (
    accept && op == cxs_pkg::OP_JUMP_LINK && misal |=>
      trap_out.cause == cxs_pkg::CAUSE_MISALIGNED && $stable(pc_r))
    else $error("misaligned jump not trapped");
  return_order_a: assert property (
    accept && op == cxs_pkg::OP_RETURN_TRAP && et |=>
      trap_out.cause == cxs_pkg::CAUSE_ILLEGAL)
    else $error("return with traps enabled not illegal");
  return_ok_a: assert property (
    accept && op == cxs_pkg::OP_RETURN_TRAP && !et && sup &&
      !wim_hit && !misal |=> et && cwp == $past(cwp_cand) &&
      npc_r == $past(sum))
    else $error("return from trap update wrong");
  soft_type_a: assert property (
    accept && op == cxs_pkg::OP_COND_TRAP && t_eval |=>
      trap_out.valid && trap_out.ttype == $past(tt_val))
    else $error("software trap type wrong");
  read_priv_a: assert property (
    accept && op == cxs_pkg::OP_READ_STATE && !sup |=>
      trap_out.cause == cxs_pkg::CAUSE_PRIVILEGED && !rf_wr_out.we)
    else $error("user state read not trapped");
  state_cwp_a: assert property (
    accept && op == cxs_pkg::OP_WRITE_STATE && bad_cwp |=>
      trap_out.cause == cxs_pkg::CAUSE_ILLEGAL && $stable(psr_r))
    else $error("bad window write not illegal");
  unimpl_hold_a: assert property (
    accept && op == cxs_pkg::OP_UNIMPL |=> trap_out.valid &&
      $stable(pc_r) && $stable(npc_r) && !rf_wr_out.we)
    else $error("unimplemented op changed state");
  stall_hold_a: assert property (
    op_valid_in && is_fbr && !fcc_valid_in |=> $stable(pc_r))
    else $error("branch ran without valid code");
endmodule : cxs_exec

/* File: cxs_cc_model.sv */
/*
 Condition code source standing in for the float unit and coprocessor.
 Assumes the bench requests codes and a delivery lag in cycles.
*/
`timescale 1ns/10ps
module cxs_cc_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // Requested codes and lag
  input  wire logic [1:0] fcode_in,
  input  wire logic [1:0] ccode_in,
  input  wire logic [3:0] lag_in,
  // Codes toward the block
  output logic [1:0]      fcc_out,
  output logic            fcc_valid_out,
  output logic [1:0]      ccc_out,
  output logic            ccc_valid_out
);
  logic [1:0] f_r;   // Last float code taken
  logic [1:0] c_r;   // Last coprocessor code taken
  logic [3:0] cnt_r; // Cycles until delivery
  logic       busy;  // Codes still being produced
  // ==========================================================
  // A new request restarts the lag
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      f_r <= 2'h0;
      c_r <= 2'h0;
      cnt_r <= 4'h0;
    end else if (fcode_in != f_r || ccode_in != c_r) begin
      f_r <= fcode_in;
      c_r <= ccode_in;
      cnt_r <= lag_in;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign busy = cnt_r != 4'h0 || fcode_in != f_r || ccode_in != c_r;
  // Stale lines show the inverse so no old value passes as fresh
  assign fcc_out = busy ? ~f_r : f_r;
  assign ccc_out = busy ? ~c_r : c_r;
  assign fcc_valid_out = !busy;
  assign ccc_valid_out = !busy;
endmodule : cxs_cc_model

/* File: control_transfer_state_access_tb_top.sv */
/*
 Self-checking bench for the execution block and its code source.
 Assumes one 100 MHz clock and the package constants.
*/
`timescale 1ns/10ps
module control_transfer_state_access_tb_top;
  logic                clk_in, nrst_in, op_valid_in, loc, ext, rdy;
  logic                fv, cv, ann, tk, ea;
  logic [31:0]         s1, s2, pc, next_program_counter, st, msk, trap_base_register, mul, ep, en;
  logic [1:0]          fcode, ccode, fcc, ccc, cd;
  logic [3:0]          lag, mk;
  cxs_pkg::cxs_instr_t ins;
  cxs_pkg::cxs_icc_t   icc;
  cxs_pkg::cxs_rf_wr_t rf;
  cxs_pkg::cxs_trap_t  tr;
  cxs_pkg::cxs_flush_t fl;
  cxs_pkg::cxs_op_t    po [6];
  int                  miscompares, comparisons, nwait;
  cxs_exec dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .op_valid_in(op_valid_in), .op_in(ins), .src1_in(s1), .src2_in(s2),
    .op_ready_out(rdy), .icc_in(icc), .fcc_in(fcc), .fcc_valid_in(fv),
    .coproc_condition_input_in(ccc), .coproc_cc_valid_in(cv),
    .local_icache_present_in(loc), .external_icache_present_in(ext),
    .pc_out(pc), .next_program_counter_out(next_program_counter), .state_out(st),
    .window_invalid_mask_out(msk), .trap_base_out(trap_base_register),
    .multiply_out(mul), .rf_wr_out(rf), .trap_out(tr), .annul_out(ann),
    .flush_out(fl));
  cxs_cc_model cc (.clk_in(clk_in), .nrst_in(nrst_in), .fcode_in(fcode),
    .ccode_in(ccode), .lag_in(lag), .fcc_out(fcc), .fcc_valid_out(fv),
    .ccc_out(ccc), .ccc_valid_out(cv));
  // ==========================================================
  // Comparison, verdict and bus tasks
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // One operation, held until accepted; results checked after the edge
  task automatic go(input cxs_pkg::cxs_op_t o, input logic [4:0] rd,
      input logic [3:0] c, input logic a, input logic [31:0] x, y);
    int n;
    @(posedge clk_in);
    #1;
    ins.op = o;
    ins.rd = rd;
    ins.cond = c;
    ins.annul = a;
    s1 = x;
    s2 = y;
    op_valid_in = 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rdy !== 1'b1 && n < 40);
    nwait = n;
    // A hung handshake ends the run as a failure
    if (n >= 40) begin
      miscompares++;
      wrap_up();
    end
    #1;
    op_valid_in = 1'b0;
  endtask : go
  task automatic fin(input cxs_pkg::cxs_cause_t c, input logic [6:0] t);
    chk({29'h0, tr}, {29'h0, c != cxs_pkg::CAUSE_NONE, c, t});
    chk({8'h0, pc}, {8'h0, ep});
    chk({8'h0, next_program_counter}, {8'h0, en});
  endtask : fin
  task automatic adv();
    ep = en;
    en = en + cxs_pkg::PC_STEP;
  endtask : adv
  task automatic rst();
    nrst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    ep = cxs_pkg::PC_RESET;
    en = cxs_pkg::NPC_RESET;
  endtask : rst
  // Integer trap relations, index 0 is never
  function automatic logic tev(input logic [2:0] s,
      input cxs_pkg::cxs_icc_t f);
    logic [7:0] r;
    r = {f.v, f.n, f.c, f.c | f.z, f.n ^ f.v, f.z | (f.n ^ f.v), f.z, 1'b0};
    return r[s];
  endfunction : tev
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #300_000;
    miscompares++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {op_valid_in, loc, ext, s1, s2, fcode, ccode, lag} = '0;
    ins = '0;
    icc = '0;
    miscompares = 0;
    comparisons = 0;
    rst();
    // Every branch mask against every code, both units, varied lag
    for (int t = 0; t < 2; t++)
      for (int k = 0; k < 4; k++)
        for (int m = 0; m < 16; m++) begin
          mk = 4'(m);
          fcode = 2'(k);
          ccode = 2'(3 - k);
          lag = 4'(k + 1);
          cd = t[0] ? ccode : fcode;
          ins.branch_displacement = mk[1] ? 22'h3F_FFFE : 22'h00_0010;
          tk = mk[cd];
          ea = (mk[0] ^ cd[0]) && (!tk || mk == 4'hF);
          go(t[0] ? cxs_pkg::OP_CP_BRANCH : cxs_pkg::OP_FP_BRANCH, 5'h00, mk,
             mk[0] ^ cd[0], 32'h0, 32'h0);
          s1 = ep + {{8{ins.branch_displacement[21]}},
                     ins.branch_displacement, 2'b00};
          ep = en;
          en = tk ? s1 : en + cxs_pkg::PC_STEP;
          fin(cxs_pkg::CAUSE_NONE, 7'h00);
          chk({39'h0, ann}, {39'h0, ea});
          // A fresh code stalls for its lag, a settled one is taken at once
          chk(40'(nwait), (m == 0) ? 40'(k + 2) : 40'h1);
        end
    // All trap conditions under two flag sets
    for (int j = 0; j < 32; j++) begin
      mk = 4'(j);
      icc = j[4] ? 4'h9 : 4'h4;
      tk = mk[3] ^ tev(mk[2:0], icc);
      go(cxs_pkg::OP_COND_TRAP, 5'h00, mk, 1'b0, 32'h1234_0000 + j,
         32'h0000_00F0);
      if (!tk) adv();
      fin(tk ? cxs_pkg::CAUSE_SOFTWARE : cxs_pkg::CAUSE_NONE,
          tk ? 7'(32'h0000_00F0 + j) : 7'h00);
    end
    ins.call_displacement = 30'h3FFF_FFFC;
    go(cxs_pkg::OP_CALL, 5'h00, 4'h0, 1'b0, 32'h0, 32'h0);
    chk({2'h0, rf}, {3'h1, cxs_pkg::LINK_REG, ep});
    s1 = ep - 32'h0000_0010;
    ep = en;
    en = s1;
    fin(cxs_pkg::CAUSE_NONE, 7'h00);
    go(cxs_pkg::OP_JUMP_LINK, 5'h05, 4'h0, 1'b0, 32'h100, 32'h2);
    fin(cxs_pkg::CAUSE_MISALIGNED, 7'h00);
    chk({39'h0, rf.we}, 40'h0);
    ins.imm_sel = 1'b1;
    ins.signed_immediate = 13'h1FFC;
    go(cxs_pkg::OP_JUMP_LINK, 5'h05, 4'h0, 1'b0, 32'h204, 32'h0);
    chk({2'h0, rf}, {3'h1, 5'h05, ep});
    ep = en;
    en = 32'h0000_0200;
    fin(cxs_pkg::CAUSE_NONE, 7'h00);
    ins.imm_sel = 1'b0;
    go(cxs_pkg::OP_JUMP_LINK, 5'h00, 4'h0, 1'b0, 32'h300, 32'h8);
    chk({39'h0, rf.we}, 40'h0);
    ep = en;
    en = 32'h0000_0308;
    fin(cxs_pkg::CAUSE_NONE, 7'h00);
    go(cxs_pkg::OP_READ_STATE, 5'h03, 4'h0, 1'b0, 32'h0, 32'h0);
    chk({2'h0, rf}, {3'h1, 5'h03, cxs_pkg::PSR_RESET});
    go(cxs_pkg::OP_WRITE_MULT, 5'h00, 4'h0, 1'b0, 32'hA5A5_0000,
       32'h0000_5A5A);
    chk({8'h0, mul}, 40'hA5A5_5A5A);
    go(cxs_pkg::OP_READ_MULT, 5'h00, 4'h0, 1'b0, 32'h0, 32'h0);
    chk({39'h0, rf.we}, 40'h0);
    go(cxs_pkg::OP_WRITE_TRAP_BASE, 5'h00, 4'h0, 1'b0, 32'hF0, 32'h0F);
    chk({8'h0, trap_base_register}, 40'hFF);
    repeat (4) adv();
    go(cxs_pkg::OP_WRITE_STATE, 5'h00, 4'h0, 1'b0, 32'h88, 32'h0);
    fin(cxs_pkg::CAUSE_ILLEGAL, 7'h00);
    go(cxs_pkg::OP_WRITE_STATE, 5'h00, 4'h0, 1'b0, 32'h87, 32'h0);
    go(cxs_pkg::OP_WRITE_MASK, 5'h00, 4'h0, 1'b0, 32'h1, 32'h0);
    chk({8'h0, st ^ msk}, 40'h86);
    go(cxs_pkg::OP_RETURN_TRAP, 5'h00, 4'h0, 1'b0, 32'h400, 32'h0);
    adv();
    adv();
    fin(cxs_pkg::CAUSE_UNDERFLOW, 7'h00);
    go(cxs_pkg::OP_WRITE_MASK, 5'h00, 4'h0, 1'b0, 32'h1, 32'h1);
    go(cxs_pkg::OP_RETURN_TRAP, 5'h00, 4'h0, 1'b0, 32'h401, 32'h0);
    adv();
    fin(cxs_pkg::CAUSE_MISALIGNED, 7'h00);
    go(cxs_pkg::OP_RETURN_TRAP, 5'h00, 4'h0, 1'b0, 32'h3F0, 32'h10);
    ep = en;
    en = 32'h0000_0400;
    fin(cxs_pkg::CAUSE_NONE, 7'h00);
    chk({8'h0, st}, 40'h20);
    go(cxs_pkg::OP_RETURN_TRAP, 5'h00, 4'h0, 1'b0, 32'h400, 32'h0);
    fin(cxs_pkg::CAUSE_ILLEGAL, 7'h00);
    go(cxs_pkg::OP_WRITE_STATE, 5'h00, 4'h0, 1'b0, 32'h09, 32'h0);
    fin(cxs_pkg::CAUSE_ILLEGAL, 7'h00);
    po = '{cxs_pkg::OP_READ_STATE, cxs_pkg::OP_READ_MASK,
           cxs_pkg::OP_READ_TRAP_BASE, cxs_pkg::OP_WRITE_MASK,
           cxs_pkg::OP_WRITE_TRAP_BASE, cxs_pkg::OP_WRITE_STATE};
    foreach (po[i]) begin
      go(po[i], 5'h03, 4'h0, 1'b0, 32'h2, 32'h0);
      fin(cxs_pkg::CAUSE_PRIVILEGED, 7'h00);
      chk({39'h0, rf.we}, 40'h0);
    end
    go(cxs_pkg::OP_READ_MULT, 5'h04, 4'h0, 1'b0, 32'h0, 32'h0);
    chk({2'h0, rf}, {3'h1, 5'h04, 32'hA5A5_5A5A});
    rst();
    go(cxs_pkg::OP_WRITE_STATE, 5'h00, 4'h0, 1'b0, 32'h80, 32'h80);
    adv();
    go(cxs_pkg::OP_RETURN_TRAP, 5'h00, 4'h0, 1'b0, 32'h400, 32'h0);
    fin(cxs_pkg::CAUSE_PRIVILEGED, 7'h00);
    go(cxs_pkg::OP_UNIMPL, 5'h00, 4'h0, 1'b0, 32'h0, 32'h0);
    fin(cxs_pkg::CAUSE_ILLEGAL, 7'h00);
    go(cxs_pkg::OP_FLUSH, 5'h00, 4'h0, 1'b0, 32'h1000, 32'h24);
    adv();
    fin(cxs_pkg::CAUSE_NONE, 7'h00);
    chk({39'h0, fl.valid}, 40'h0);
    loc = 1'b1;
    go(cxs_pkg::OP_FLUSH, 5'h00, 4'h0, 1'b0, 32'h1000, 32'h24);
    chk({7'h0, fl}, {8'h1, 32'h0000_1024});
    loc = 1'b0;
    ext = 1'b1;
    go(cxs_pkg::OP_FLUSH, 5'h00, 4'h0, 1'b0, 32'h1000, 32'h24);
    adv();
    fin(cxs_pkg::CAUSE_ILLEGAL, 7'h00);
    chk({39'h0, fl.valid}, 40'h0);
    wrap_up();
  end
endmodule : control_transfer_state_access_tb_top
